// ### eee_lpi_ctrl.sv
// Low-power idle control between MAC interface, line side and management registers
`timescale 1ns/1ps
module eee_lpi_ctrl #(
    parameter bit P_RMII       = 1'b0,
    parameter int P_PERIOD_CYC = eee_pkg::REFRESH_PERIOD_CYC,
    parameter int P_BURST_CYC  = eee_pkg::REFRESH_BURST_CYC
) (
    // System clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_sys_rst,
    // Management access
    input  wire eee_pkg::eee_mgmt_req_type i_mgmt_req,
    output logic                           o_mgmt_rvalid,
    output logic [15:0]                    o_mgmt_rdata,
    // Auto-negotiation and analog controls
    input  wire logic [15:0]               i_partner_adv,
    output logic                           o_an_restart,
    output logic                           o_tenbase_te,
    // Link clock (MII/RMII reference timing)
    input  wire logic                      i_clk_link,
    // MAC transmit side
    input  wire eee_pkg::eee_nibble_type   i_mac_tx,
    output logic                           o_tx_clk_en,
    // Line transmit side
    output logic                           o_line_tx_en,
    output logic [3:0]                     o_line_txd,
    output logic                           o_line_refresh,
    output logic                           o_line_quiet,
    // Line receive side
    input  wire logic                      i_line_sleep,
    input  wire eee_pkg::eee_nibble_type   i_line_rx,
    // MAC receive side
    output logic                           o_rx_dv,
    output logic                           o_rx_er,
    output logic [3:0]                     o_rxd,
    output logic                           o_rx_clk_en
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [15:0] basic_ctrl_reg;
    logic [15:0] afe_ctrl_four_reg;
    logic [15:0] pma_ctrl_reg;
    logic [15:0] pcs_ctrl_reg;
    logic [15:0] local_adv_reg;
    logic [15:0] mmd_ctrl_reg;
    logic [15:0] mmd_addr_reg;
    logic        rvalid_reg;
    logic [15:0] rdata_reg;
    logic        an_restart_reg;

    // ------------------------------------------------------------
    // Direct and indirect decode
    // ------------------------------------------------------------
    wire [4:0] mmd_dev      = mmd_ctrl_reg[4:0];
    wire [1:0] mmd_func     = mmd_ctrl_reg[eee_pkg::MMD_FUNC_HI:eee_pkg::MMD_FUNC_LO];
    wire       sel_basic    = (i_mgmt_req.addr == eee_pkg::STD_BASIC_CONTROL);
    wire       sel_afe      = (i_mgmt_req.addr == eee_pkg::STD_AFE_CONTROL_FOUR);
    wire       sel_mctrl    = (i_mgmt_req.addr == eee_pkg::STD_MMD_ACCESS_CTRL);
    wire       sel_mdata    = (i_mgmt_req.addr == eee_pkg::STD_MMD_ACCESS_DATA);
    wire       mdata_addr   = sel_mdata && (mmd_func == eee_pkg::MMD_FUNC_ADDRESS);
    wire       mdata_reg    = sel_mdata && (mmd_func != eee_pkg::MMD_FUNC_ADDRESS);
    wire       sel_pma_ctrl = mdata_reg && (mmd_dev == eee_pkg::MMD_DEV_PMA_PMD)
                              && (mmd_addr_reg == eee_pkg::MMD_PMA_PMD_CONTROL);
    wire       sel_pma_stat = mdata_reg && (mmd_dev == eee_pkg::MMD_DEV_PMA_PMD)
                              && (mmd_addr_reg == eee_pkg::MMD_PMA_PMD_STATUS);
    wire       sel_pcs_ctrl = mdata_reg && (mmd_dev == eee_pkg::MMD_DEV_PCS)
                              && (mmd_addr_reg == eee_pkg::MMD_PCS_CONTROL);
    wire       sel_loc_adv  = mdata_reg && (mmd_dev == eee_pkg::MMD_DEV_AUTONEG)
                              && (mmd_addr_reg == eee_pkg::MMD_EEE_LOCAL_ADV);
    wire       sel_par_adv  = mdata_reg && (mmd_dev == eee_pkg::MMD_DEV_AUTONEG)
                              && (mmd_addr_reg == eee_pkg::MMD_EEE_PARTNER_ADV);
    wire       wr           = i_mgmt_req.wr;

    // ------------------------------------------------------------
    // Status and enables seen by the system domain
    // ------------------------------------------------------------
    logic [1:0]  lpi_sys;
    wire         tx_lpi_sys = lpi_sys[0];
    wire         rx_lpi_sys = lpi_sys[1];
    wire         eee_enable = local_adv_reg[eee_pkg::BIT_ADV_100_EEE]
                              && i_partner_adv[eee_pkg::BIT_ADV_100_EEE];
    wire         rxc_stop_en = pcs_ctrl_reg[eee_pkg::BIT_RXC_STOP_EN] && !P_RMII;
    logic [15:0] pma_status;

    always_comb begin
        pma_status = 16'h0000;
        pma_status[eee_pkg::BIT_STAT_RX_LPI] = rx_lpi_sys;
        pma_status[eee_pkg::BIT_STAT_TX_LPI] = tx_lpi_sys;
    end

    wire [15:0] rd_mux = sel_basic    ? basic_ctrl_reg    :
                         sel_afe      ? afe_ctrl_four_reg :
                         sel_mctrl    ? mmd_ctrl_reg      :
                         mdata_addr   ? mmd_addr_reg      :
                         sel_pma_ctrl ? pma_ctrl_reg      :
                         sel_pma_stat ? pma_status        :
                         sel_pcs_ctrl ? pcs_ctrl_reg      :
                         sel_loc_adv  ? local_adv_reg     :
                         sel_par_adv  ? i_partner_adv     : 16'h0000;

    // ------------------------------------------------------------
    // Management writes and reads
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            basic_ctrl_reg    <= eee_pkg::RST_BASIC_CONTROL;
            afe_ctrl_four_reg <= eee_pkg::RST_AFE_CONTROL_FOUR;
            mmd_ctrl_reg      <= eee_pkg::RST_MMD_ACCESS;
            mmd_addr_reg      <= eee_pkg::RST_MMD_ACCESS;
            an_restart_reg    <= 1'b0;
        end else begin
            an_restart_reg <= wr && sel_basic && i_mgmt_req.wdata[eee_pkg::BIT_AN_RESTART];
            if (wr && sel_basic) begin
                basic_ctrl_reg <= i_mgmt_req.wdata;
            end else begin
                basic_ctrl_reg[eee_pkg::BIT_AN_RESTART] <= 1'b0;
            end
            if (wr && sel_afe) begin
                afe_ctrl_four_reg <= i_mgmt_req.wdata;
            end
            if (wr && sel_mctrl) begin
                mmd_ctrl_reg <= i_mgmt_req.wdata;
            end
            if (wr && mdata_addr) begin
                mmd_addr_reg <= i_mgmt_req.wdata;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pma_ctrl_reg  <= eee_pkg::RST_PMA_PMD_CONTROL;
            pcs_ctrl_reg  <= eee_pkg::RST_PCS_CONTROL;
            local_adv_reg <= eee_pkg::RST_EEE_LOCAL_ADV;
            rvalid_reg    <= 1'b0;
            rdata_reg     <= 16'h0000;
        end else begin
            if (wr && sel_pma_ctrl) begin
                pma_ctrl_reg <= i_mgmt_req.wdata;
            end
            if (wr && sel_pcs_ctrl) begin
                pcs_ctrl_reg <= i_mgmt_req.wdata;
            end
            if (wr && sel_loc_adv) begin
                local_adv_reg <= i_mgmt_req.wdata;
            end
            rvalid_reg <= i_mgmt_req.rd && !wr;
            if (i_mgmt_req.rd && !wr) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign o_mgmt_rvalid = rvalid_reg;
    assign o_mgmt_rdata  = rdata_reg;
    assign o_an_restart  = an_restart_reg;
    assign o_tenbase_te  = afe_ctrl_four_reg[eee_pkg::BIT_TENBASE_TE];

    // ------------------------------------------------------------
    // Refresh timing during transmit idle
    // ------------------------------------------------------------
    eee_refresh_timer #(
        .PERIOD_CYC (P_PERIOD_CYC),
        .BURST_CYC  (P_BURST_CYC)
    ) u_refresh (
        .i_clk      (i_clk_sys),
        .i_rst      (i_sys_rst),
        .i_active   (tx_lpi_sys),
        .o_refresh  (o_line_refresh),
        .o_quiet    (o_line_quiet)
    );

    // ------------------------------------------------------------
    // Crossings between domains
    // ------------------------------------------------------------
    logic       rst_link;
    logic [1:0] cfg_link;
    logic       tx_lpi_reg;
    logic       rx_lpi_reg;

    eee_sync3 #(.W(1)) u_rst_sync (
        .i_clk   (i_clk_link),
        .i_rst   (1'b0),
        .i_async (i_sys_rst),
        .o_sync  (rst_link)
    );

    eee_sync3 #(.W(2)) u_cfg_sync (
        .i_clk   (i_clk_link),
        .i_rst   (rst_link),
        .i_async ({rxc_stop_en, eee_enable}),
        .o_sync  (cfg_link)
    );

    eee_sync3 #(.W(2)) u_stat_sync (
        .i_clk   (i_clk_sys),
        .i_rst   (i_sys_rst),
        .i_async ({rx_lpi_reg, tx_lpi_reg}),
        .o_sync  (lpi_sys)
    );

    wire eee_link     = cfg_link[0];
    wire rxc_stop_lnk = cfg_link[1];

    // ------------------------------------------------------------
    // Transmit direction (link domain)
    // ------------------------------------------------------------
    wire tx_req_mii  = !i_mac_tx.dv && i_mac_tx.er
                       && (i_mac_tx.data == eee_pkg::MII_LPI_CODE);
    wire tx_req_rmii = !i_mac_tx.dv
                       && (i_mac_tx.data[1:0] == eee_pkg::RMII_LPI_CODE);
    wire tx_req      = (P_RMII ? tx_req_rmii : tx_req_mii) && eee_link;

    logic       line_tx_en_reg;
    logic [3:0] line_txd_reg;
    logic       tx_clk_en_reg;

    always_ff @(posedge i_clk_link) begin
        if (rst_link) begin
            tx_lpi_reg     <= 1'b0;
            line_tx_en_reg <= 1'b0;
            line_txd_reg   <= 4'h0;
            tx_clk_en_reg  <= 1'b0;
        end else begin
            tx_lpi_reg     <= tx_req;
            line_tx_en_reg <= i_mac_tx.dv;
            line_txd_reg   <= i_mac_tx.data;
            tx_clk_en_reg  <= 1'b1;
        end
    end

    assign o_line_tx_en = line_tx_en_reg;
    assign o_line_txd   = line_txd_reg;
    assign o_tx_clk_en  = tx_clk_en_reg;

    // ------------------------------------------------------------
    // Receive direction (link domain)
    // ------------------------------------------------------------
    localparam int SW = $clog2(eee_pkg::RXC_STOP_CYCLES + 1);
    localparam logic [SW-1:0] STOP_AT = SW'(eee_pkg::RXC_STOP_CYCLES);

    logic          rx_dv_reg;
    logic          rx_er_reg;
    logic [3:0]    rxd_reg;
    logic [SW-1:0] idle_cnt_reg;
    logic          rx_clk_en_reg;

    wire           rx_enter  = i_line_sleep && eee_link;
    wire           cnt_full  = (idle_cnt_reg == STOP_AT);
    wire [3:0]     lpi_rxd   = P_RMII ? {2'h0, eee_pkg::RMII_LPI_CODE} : eee_pkg::MII_LPI_CODE;

    always_ff @(posedge i_clk_link) begin
        if (rst_link) begin
            rx_lpi_reg <= 1'b0;
            rx_dv_reg  <= 1'b0;
            rx_er_reg  <= 1'b0;
            rxd_reg    <= 4'h0;
        end else if (rx_enter) begin
            rx_lpi_reg <= 1'b1;
            rx_dv_reg  <= 1'b0;
            rx_er_reg  <= !P_RMII;
            rxd_reg    <= lpi_rxd;
        end else begin
            rx_lpi_reg <= 1'b0;
            rx_dv_reg  <= i_line_rx.dv;
            rx_er_reg  <= i_line_rx.er;
            rxd_reg    <= i_line_rx.data;
        end
    end

    always_ff @(posedge i_clk_link) begin
        if (rst_link) begin
            idle_cnt_reg  <= '0;
            rx_clk_en_reg <= 1'b1;
        end else begin
            if (!rx_lpi_reg || !rx_enter) begin
                idle_cnt_reg <= '0;
            end else if (!cnt_full) begin
                idle_cnt_reg <= idle_cnt_reg + SW'(1);
            end
            rx_clk_en_reg <= !(rxc_stop_lnk && cnt_full && rx_lpi_reg && rx_enter);
        end
    end

    assign o_rx_dv     = rx_dv_reg;
    assign o_rx_er     = rx_er_reg;
    assign o_rxd       = rxd_reg;
    assign o_rx_clk_en = rx_clk_en_reg;

endmodule : eee_lpi_ctrl

// ### eee_lpi_ctrl_sva.sv
// Checker: concurrent assertions on the low-power idle control ports
`timescale 1ns/1ps
module eee_lpi_ctrl_chk #(
    parameter int P_BURST_CYC = 20
) (
    // Clocks and reset
    input wire logic                      i_clk_sys,
    input wire logic                      i_sys_rst,
    input wire logic                      i_clk_link,
    // Watched ports
    input wire eee_pkg::eee_mgmt_req_type i_mgmt_req,
    input wire logic                      o_mgmt_rvalid,
    input wire logic                      o_an_restart,
    input wire logic                      o_tenbase_te,
    input wire eee_pkg::eee_nibble_type   i_mac_tx,
    input wire logic                      o_tx_clk_en,
    input wire logic                      o_line_tx_en,
    input wire logic [3:0]                o_line_txd,
    input wire logic                      o_line_refresh,
    input wire logic                      o_line_quiet,
    input wire logic                      i_line_sleep,
    input wire eee_pkg::eee_nibble_type   i_line_rx,
    input wire logic                      o_rx_dv,
    input wire logic                      o_rx_er,
    input wire logic [3:0]                o_rxd,
    input wire logic                      o_rx_clk_en
);
    logic [31:0] burst_cnt_reg;
    wire         rx_lpi     = !o_rx_dv && o_rx_er && (o_rxd == eee_pkg::MII_LPI_CODE);
    wire         restart_wr = i_mgmt_req.wr && (i_mgmt_req.addr == eee_pkg::STD_BASIC_CONTROL)
                              && i_mgmt_req.wdata[9];
    wire         afe_wr     = i_mgmt_req.wr && (i_mgmt_req.addr == eee_pkg::STD_AFE_CONTROL_FOUR);
    wire         te_bit     = i_mgmt_req.wdata[eee_pkg::BIT_TENBASE_TE];
    always_ff @(posedge i_clk_sys) begin
        burst_cnt_reg <= o_line_refresh ? burst_cnt_reg + 32'h1 : 32'h0;
    end
    a_read_answer: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_mgmt_rvalid == $past(i_mgmt_req.rd && !i_mgmt_req.wr)) else $error("rvalid");
    a_an_restart: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_an_restart == $past(restart_wr)) else $error("restart");
    a_tenbase_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $past(afe_wr) |-> o_tenbase_te == $past(te_bit)) else $error("te mode");
    a_refresh_excl: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !(o_line_refresh && o_line_quiet)) else $error("overlap");
    a_burst_len: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        $fell(o_line_refresh) && o_line_quiet |-> burst_cnt_reg == 32'(P_BURST_CYC)) else $error("burst");
    a_tx_copy: assert property (@(posedge i_clk_link) disable iff (i_sys_rst)
        o_line_tx_en == $past(i_mac_tx.dv) && o_line_txd == $past(i_mac_tx.data)) else $error("tx copy");
    a_tx_clk_run: assert property (@(posedge i_clk_link) disable iff (i_sys_rst)
        $past(o_tx_clk_en) |-> o_tx_clk_en) else $error("txc stop");
    a_rx_pass: assert property (@(posedge i_clk_link) disable iff (i_sys_rst)
        !$past(i_line_sleep) |-> o_rx_dv == $past(i_line_rx.dv) && o_rx_er == $past(i_line_rx.er)
        && o_rxd == $past(i_line_rx.data)) else $error("rx copy");
    a_rx_lpi_hold: assert property (@(posedge i_clk_link) disable iff (i_sys_rst)
        i_line_sleep && rx_lpi |=> rx_lpi) else $error("rx lpi");
    a_rx_clk_stop: assert property (@(posedge i_clk_link) disable iff (i_sys_rst)
        $fell(o_rx_clk_en) |-> $past(i_line_sleep, 9)) else $error("rxc early");
    a_rx_clk_wake: assert property (@(posedge i_clk_link) disable iff (i_sys_rst)
        !$past(i_line_sleep) |-> o_rx_clk_en) else $error("rxc off");
endmodule : eee_lpi_ctrl_chk

bind eee_lpi_ctrl eee_lpi_ctrl_chk #(.P_BURST_CYC(P_BURST_CYC)) u_eee_lpi_ctrl_chk (
    .i_clk_sys, .i_sys_rst, .i_clk_link, .i_mgmt_req, .o_mgmt_rvalid, .o_an_restart, .o_tenbase_te,
    .i_mac_tx, .o_tx_clk_en, .o_line_tx_en, .o_line_txd, .o_line_refresh, .o_line_quiet,
    .i_line_sleep, .i_line_rx, .o_rx_dv, .o_rx_er, .o_rxd, .o_rx_clk_en);

// ### eee_lpi_ctrl_tb_top.sv
// Testbench: register, transmit idle and receive idle scenarios
`timescale 1ns/1ps
module eee_lpi_ctrl_tb_top;
    logic                      clk_sys = 1'b0;
    logic                      clk_link = 1'b0;
    logic                      rst = 1'b1;
    eee_pkg::eee_mgmt_req_type req = '0;
    logic [15:0]               partner_adv = 16'h0002;
    logic [1:0]                tx_sel = 2'h0;
    logic [1:0]                rx_sel = 2'h0;
    eee_pkg::eee_nibble_type   mac_tx, line_rx;
    logic                      line_sleep, rvalid, restart, refresh, quiet, rx_dv, rx_er, rx_clk_en;
    logic [15:0]               rdata;
    logic [3:0]                rxd;
    int                        failures = 0;
    int                        num_checks = 0;
    int                        restarts = 0;
    always #5 clk_sys = ~clk_sys;
    always #62.5 clk_link = ~clk_link;
    always @(posedge clk_sys) if (restart === 1'b1) restarts++;
    eee_lpi_ctrl #(.P_RMII(1'b0), .P_PERIOD_CYC(200), .P_BURST_CYC(20)) u_eee_lpi_ctrl (
        .i_clk_sys(clk_sys), .i_sys_rst(rst), .i_mgmt_req(req), .o_mgmt_rvalid(rvalid), .o_mgmt_rdata(rdata),
        .i_partner_adv(partner_adv), .o_an_restart(restart), .o_tenbase_te(), .i_clk_link(clk_link),
        .i_mac_tx(mac_tx), .o_tx_clk_en(), .o_line_tx_en(), .o_line_txd(), .o_line_refresh(refresh),
        .o_line_quiet(quiet), .i_line_sleep(line_sleep), .i_line_rx(line_rx), .o_rx_dv(rx_dv),
        .o_rx_er(rx_er), .o_rxd(rxd), .o_rx_clk_en(rx_clk_en));
    eee_mac_model u_eee_mac_model (.i_clk_link(clk_link), .i_tx_sel(tx_sel), .i_rx_sel(rx_sel),
        .o_mac_tx(mac_tx), .o_line_sleep(line_sleep), .o_line_rx(line_rx));
    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    function automatic logic pick(input int sel);
        return (sel == 0) ? refresh : (sel == 1) ? quiet : rx_dv;
    endfunction : pick
    task automatic wait_for(input int sel, input logic val, input int lim);
        for (int n = 0; n < lim && pick(sel) !== val; n++) @(negedge clk_sys);
        check("wait signal", {15'h0, val}, {15'h0, pick(sel)});
        if (pick(sel) !== val) wrap_up();
    endtask : wait_for
    task automatic mgmt(input logic wr, input logic [4:0] addr, input logic [15:0] wd, output logic [15:0] rd);
        @(negedge clk_sys);
        req = {wr, ~wr, addr, wd};
        @(negedge clk_sys);
        req = '0;
        if (!wr) begin
            for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk_sys);
            check("read valid", 16'h1, {15'h0, rvalid});
            rd = rdata;
        end
    endtask : mgmt
    task automatic mmd(input logic wr, input logic [4:0] dev, input logic [15:0] regn, wd, output logic [15:0] rd);
        mgmt(1'b1, 5'h0D, {11'h0, dev}, rd);
        mgmt(1'b1, 5'h0E, regn, rd);
        mgmt(1'b1, 5'h0D, {2'h1, 9'h0, dev}, rd);
        mgmt(wr, 5'h0E, wd, rd);
    endtask : mmd
    task automatic t_regs;
        logic [15:0] d;
        mmd(1'b0, 5'h03, 16'h0000, 16'h0000, d);
        check("pcs control", eee_pkg::RST_PCS_CONTROL, d);
        mmd(1'b0, 5'h07, 16'h003C, 16'h0000, d);
        check("local adv", 16'h0000, d);
        mmd(1'b1, 5'h07, 16'h003D, 16'hFFFF, d);
        mmd(1'b0, 5'h07, 16'h003D, 16'h0000, d);
        check("partner adv", 16'h0002, d);
        mgmt(1'b0, 5'h1F, 16'h0000, d);
        check("unmapped", 16'h0000, d);
        rx_sel = 2'h1;
        repeat (14) @(negedge clk_link);
        check("rx disabled", 16'h0001, {14'h0, rx_er, rx_clk_en});
        rx_sel = 2'h0;
        mgmt(1'b1, 5'h13, 16'h0010, d);
        mgmt(1'b1, 5'h13, 16'h0000, d);
        mmd(1'b1, 5'h07, 16'h003C, 16'h0002, d);
        mgmt(1'b1, 5'h00, 16'h0200, d);
        repeat (2) @(negedge clk_sys);
        check("restart count", 16'h1, 16'(restarts));
        $display("t_regs done");
    endtask : t_regs
    task automatic t_tx;
        logic [15:0] d;
        tx_sel = 2'h1;
        wait_for(0, 1'b1, 100);
        wait_for(1, 1'b1, 40);
        wait_for(0, 1'b1, 250);
        mmd(1'b0, 5'h01, 16'h0001, 16'h0000, d);
        check("tx status", 16'h2, {14'h0, d[9:8]});
        tx_sel = 2'h2;
        wait_for(0, 1'b0, 50);
        wait_for(1, 1'b0, 50);
        tx_sel = 2'h3;
        repeat (4) @(negedge clk_link);
        tx_sel = 2'h0;
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx;
        logic [15:0] d;
        rx_sel = 2'h1;
        repeat (4) @(negedge clk_link);
        check("rx idle code", 16'h0011, {10'h0, rx_dv, rx_er, rxd});
        repeat (12) @(negedge clk_link);
        check("rx clock", 16'h0, {15'h0, rx_clk_en});
        mmd(1'b0, 5'h01, 16'h0001, 16'h0000, d);
        check("rx status", 16'h1, {14'h0, d[9:8]});
        rx_sel = 2'h2;
        wait_for(2, 1'b1, 40);
        check("rx clock back", 16'h1, {15'h0, rx_clk_en});
        mmd(1'b1, 5'h03, 16'h0000, 16'h0000, d);
        rx_sel = 2'h1;
        repeat (16) @(negedge clk_link);
        check("rx clock kept", 16'h1, {15'h0, rx_clk_en});
        rx_sel = 2'h0;
        $display("t_rx done");
    endtask : t_rx
    initial begin
        repeat (90000) @(posedge clk_sys);
        failures++;
        $display("ERROR watchdog expected finish seen hang");
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk_link);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (8) @(posedge clk_link);
        t_regs();
        t_tx();
        t_rx();
        wrap_up();
    end
endmodule : eee_lpi_ctrl_tb_top

// ### eee_mac_model.sv
// Partner model: MAC transmit side and link partner receive code groups
`timescale 1ns/1ps
module eee_mac_model (
    // Link clock and commands
    input  wire logic              i_clk_link,
    input  wire logic [1:0]        i_tx_sel,
    input  wire logic [1:0]        i_rx_sel,
    // Driven signals
    output eee_pkg::eee_nibble_type o_mac_tx = '0,
    output logic                    o_line_sleep = 1'b0,
    output eee_pkg::eee_nibble_type o_line_rx = '0
);
    logic [3:0] cnt_reg = 4'h0;
    always @(negedge i_clk_link) begin
        cnt_reg <= cnt_reg + 4'h1;
        case (i_tx_sel)
            2'h1: o_mac_tx <= {1'b0, 1'b1, eee_pkg::MII_LPI_CODE};
            2'h2: o_mac_tx <= {1'b0, 1'b0, eee_pkg::MII_LPI_CODE};
            2'h3: o_mac_tx <= {1'b1, 1'b0, cnt_reg};
            default: o_mac_tx <= '0;
        endcase
        o_line_sleep <= (i_rx_sel == 2'h1);
        if (i_rx_sel == 2'h2) begin
            o_line_rx <= {1'b1, 1'b0, cnt_reg};
        end else begin
            o_line_rx <= {1'b0, 1'b0, (i_rx_sel == 2'h1) ? ~cnt_reg : 4'h0};
        end
    end
endmodule : eee_mac_model

// ### eee_pkg.sv
// Package: register map, field positions, reset values, timing and carrier types for the EEE LPI block
package eee_pkg;

    // ------------------------------------------------------------
    // Management register numbers
    // ------------------------------------------------------------
    localparam logic [4:0]  STD_BASIC_CONTROL     = 5'h00;
    localparam logic [4:0]  STD_AFE_CONTROL_FOUR  = 5'h13;
    localparam logic [4:0]  STD_MMD_ACCESS_CTRL   = 5'h0D;
    localparam logic [4:0]  STD_MMD_ACCESS_DATA   = 5'h0E;
    localparam logic [4:0]  MMD_DEV_PMA_PMD       = 5'h01;
    localparam logic [4:0]  MMD_DEV_PCS           = 5'h03;
    localparam logic [4:0]  MMD_DEV_AUTONEG       = 5'h07;
    localparam logic [15:0] MMD_PMA_PMD_CONTROL   = 16'h0000;
    localparam logic [15:0] MMD_PMA_PMD_STATUS    = 16'h0001;
    localparam logic [15:0] MMD_PCS_CONTROL       = 16'h0000;
    localparam logic [15:0] MMD_EEE_LOCAL_ADV     = 16'h003C;
    localparam logic [15:0] MMD_EEE_PARTNER_ADV   = 16'h003D;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          BIT_AN_RESTART        = 9;
    localparam int          BIT_TENBASE_TE        = 4;
    localparam int          BIT_ADV_100_EEE       = 1;
    localparam int          BIT_RXC_STOP_EN       = 10;
    localparam int          BIT_STAT_RX_LPI       = 8;
    localparam int          BIT_STAT_TX_LPI       = 9;
    localparam int          MMD_FUNC_HI           = 15;
    localparam int          MMD_FUNC_LO           = 14;
    localparam logic [1:0]  MMD_FUNC_ADDRESS      = 2'h0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_BASIC_CONTROL     = 16'h0000;
    localparam logic [15:0] RST_AFE_CONTROL_FOUR  = 16'h0000;
    localparam logic [15:0] RST_PMA_PMD_CONTROL   = 16'h0000;
    localparam logic [15:0] RST_PCS_CONTROL       = 16'h0400;
    localparam logic [15:0] RST_EEE_LOCAL_ADV     = 16'h0000;
    localparam logic [15:0] RST_MMD_ACCESS        = 16'h0000;

    // ------------------------------------------------------------
    // Idle request codes and timing
    // ------------------------------------------------------------
    localparam logic [3:0]  MII_LPI_CODE          = 4'h1;
    localparam logic [1:0]  RMII_LPI_CODE         = 2'h1;
    localparam int          RXC_STOP_CYCLES       = 9;
    localparam int          SYS_CLK_MHZ           = 100;
    localparam int          REFRESH_PERIOD_MS     = 20;
    localparam int          REFRESH_BURST_US      = 200;
    localparam int          REFRESH_PERIOD_CYC    = REFRESH_PERIOD_MS * 1000 * SYS_CLK_MHZ;
    localparam int          REFRESH_BURST_CYC     = REFRESH_BURST_US * SYS_CLK_MHZ;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } eee_mgmt_req_type;

    typedef struct packed {
        logic        dv;
        logic        er;
        logic [3:0]  data;
    } eee_nibble_type;

endpackage : eee_pkg

// ### eee_refresh_timer.sv
// Refresh burst and quiet period timer for transmit low-power idle
`timescale 1ns/1ps
module eee_refresh_timer #(
    parameter int PERIOD_CYC = eee_pkg::REFRESH_PERIOD_CYC,
    parameter int BURST_CYC  = eee_pkg::REFRESH_BURST_CYC
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Control
    input  wire logic i_active,
    // Line state
    output logic      o_refresh,
    output logic      o_quiet
);

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] LAST  = CW'(PERIOD_CYC - 1);
    localparam logic [CW-1:0] BURST = CW'(BURST_CYC);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          refresh_reg;
    logic          quiet_reg;
    wire           wrap      = (cnt_reg == LAST);
    wire           in_burst  = (cnt_next < BURST);

    assign cnt_next = !i_active ? LAST : (wrap ? '0 : cnt_reg + CW'(1));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg     <= LAST;
            refresh_reg <= 1'b0;
            quiet_reg   <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            refresh_reg <= i_active && in_burst;
            quiet_reg   <= i_active && !in_burst;
        end
    end

    assign o_refresh = refresh_reg;
    assign o_quiet   = quiet_reg;

endmodule : eee_refresh_timer

// ### eee_sync3.sv
// Three-stage synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
module eee_sync3 #(
    parameter int W = 1
) (
    // Destination clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;

    always_ff @(posedge i_clk) begin
        s1_reg <= i_async;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    out_reg[g] <= 1'b0;
                end else if (s2_reg[g] == s3_reg[g]) begin
                    out_reg[g] <= s3_reg[g];
                end
            end
        end
    endgenerate

    assign o_sync = out_reg;

endmodule : eee_sync3
